// ### rtl/ppf_an_end.sv
// Purpose: access network protection protocol entity
// Assumes: one management request or link message per cycle, same clock
// Notes:   link messages take priority over management requests
`timescale 1ns/10ps
module ppf_an_end
  import ppf_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  ppf_link_if.an_end       link,
  input  wire logic        mgmt_ack_i,
  input  wire logic        mgmt_req_i,
  input  wire logic        mgmt_rej_i,
  input  wire logic        misalign_i,
  input  wire logic        seq_inc_s_i,
  input  wire logic        seq_inc_r_i,
  output ppf_state_type    state_o,
  output ppf_ind_type      ind_o,
  output logic             ind_valid_o,
  output logic [SEQ_W-1:0] send_sequence_variable_o,
  output logic [SEQ_W-1:0] receive_sequence_variable_o
);
  ppf_state_type    state_reg, state_next;
  logic [TMR_W-1:0] req_cnt_reg, rst_cnt_reg, grd_cnt_reg;
  logic             req_run_reg, rst_run_reg, grd_run_reg;
  logic             req_second_reg, rst_second_reg;
  logic [SEQ_W-1:0] vs_reg, vr_reg;
  logic             tx_valid_reg;
  ppf_msg_type      tx_msg_reg;
  logic [3:0]       tx_cause_reg;
  logic [7:0]       tx_diag_reg;
  ppf_ind_type      ind_reg;
  logic             ind_valid_reg;

  // decode of the current event
  wire logic rx        = link.le_valid;
  wire logic rx_bad    = rx && !(link.le_len_ok && link.le_code_ok);
  wire logic rx_good   = rx && !rx_bad;
  wire logic in_null   = (state_reg == null_state);
  wire logic in_anreq  = (state_reg == requested_by_access_network_state);
  wire logic in_lereq  = (state_reg == requested_by_exchange_state);
  wire logic req_exp   = req_run_reg && (req_cnt_reg == '0);
  wire logic rst_exp   = rst_run_reg && (rst_cnt_reg == '0);
  wire logic grd_exp   = grd_run_reg && (grd_cnt_reg == '0);
  wire logic rx_com    = rx_good && (link.le_msg == PPF_MSG_SO_COM);
  wire logic rx_os     = rx_good && (link.le_msg == PPF_MSG_OS_COM);
  wire logic rx_rej    = rx_good && (link.le_msg == PPF_MSG_SO_REJ);
  wire logic rx_rstc   = rx_good && (link.le_msg == PPF_MSG_RST_COM);
  wire logic rx_rsta   = rx_good && (link.le_msg == PPF_MSG_RST_ACK);
  wire logic rx_other  = rx_good && !(rx_com || rx_os || rx_rej || rx_rstc || rx_rsta);
  wire logic mg_any    = !rx && !misalign_i && (mgmt_ack_i || mgmt_req_i || mgmt_rej_i);
  wire logic mg_ack    = mg_any && mgmt_ack_i;
  wire logic mg_req    = mg_any && !mgmt_ack_i && mgmt_req_i;
  wire logic mg_rej    = mg_any && !mgmt_ack_i && !mgmt_req_i;
  wire logic ev_misal  = !rx && misalign_i;
  // unexpected: messages outside their states; stray management requests do nothing
  wire logic unexp     = ((rx_com || rx_os) && in_lereq)
                       || (rx_rej && !in_anreq)
                       || rx_other;
  wire logic prot_err  = rx_bad || unexp;
  wire logic send_err  = prot_err && !rst_run_reg;
  wire logic do_reset  = ev_misal || (rx_rstc && !prot_err);
  wire logic take_com  = (rx_com || rx_os) && !in_lereq;
  wire logic req_start = (mg_req && in_null) || (req_exp && in_anreq && !req_second_reg);
  wire logic req_stop  = do_reset || take_com || (rx_rej && in_anreq)
                       || (req_exp && req_second_reg) || (req_exp && !in_anreq);
  wire logic rst_start = ev_misal || (rst_exp && !rst_second_reg);

  always_comb begin
    state_next = state_reg;
    if (do_reset) begin
      state_next = null_state;
    end else if (take_com) begin
      state_next = requested_by_exchange_state;
    end else if ((rx_rej && in_anreq) || ((mg_ack || mg_rej) && in_lereq)) begin
      state_next = null_state;
    end else if (mg_req && in_null) begin
      state_next = requested_by_access_network_state;
    end else if (req_exp && in_anreq && req_second_reg) begin
      state_next = null_state;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= null_state;
    end else begin
      state_reg <= state_next;
    end
  end

  // tick counters loaded with nominal count minus one; request and reset timers restart once at first expiry, guard timer one-shot
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      req_cnt_reg    <= '0;
      req_run_reg    <= 1'b0;
      req_second_reg <= 1'b0;
    end else if (req_stop) begin
      // a stop in the cycle of a first expiry must not restart the timer
      req_run_reg    <= 1'b0;
      req_second_reg <= 1'b0;
    end else if (req_start) begin
      req_cnt_reg    <= TMR_W'(REQ_CYCLES - 1);
      req_run_reg    <= 1'b1;
      req_second_reg <= !(mg_req && in_null);
    end else if (req_run_reg) begin
      req_cnt_reg    <= req_cnt_reg - TMR_W'(1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cnt_reg    <= '0;
      rst_run_reg    <= 1'b0;
      rst_second_reg <= 1'b0;
    end else if (rst_start) begin
      rst_cnt_reg    <= TMR_W'(RST_CYCLES - 1);
      rst_run_reg    <= 1'b1;
      rst_second_reg <= !ev_misal;
    end else if (rx_rsta || rst_exp) begin
      rst_run_reg    <= 1'b0;
      rst_second_reg <= 1'b0;
    end else if (rst_run_reg) begin
      rst_cnt_reg    <= rst_cnt_reg - TMR_W'(1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      grd_cnt_reg <= '0;
      grd_run_reg <= 1'b0;
    end else if (rx_rstc && !prot_err) begin
      grd_cnt_reg <= TMR_W'(GRD_CYCLES - 1);
      grd_run_reg <= 1'b1;
    end else if (grd_exp) begin
      grd_run_reg <= 1'b0;
    end else if (grd_run_reg) begin
      grd_cnt_reg <= grd_cnt_reg - TMR_W'(1);
    end
  end

  // sequence variables
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vs_reg <= SEQ_RESET;
      vr_reg <= SEQ_RESET;
    end else if (do_reset || (rst_exp && !rst_second_reg)) begin
      vs_reg <= SEQ_RESET;
      vr_reg <= SEQ_RESET;
    end else begin
      vs_reg <= vs_reg + SEQ_W'(seq_inc_s_i);
      vr_reg <= vr_reg + SEQ_W'(seq_inc_r_i);
    end
  end

  // outgoing message and management indication
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_reg  <= 1'b0;
      tx_msg_reg    <= PPF_MSG_NONE;
      tx_cause_reg  <= 4'h0;
      tx_diag_reg   <= 8'h00;
      ind_reg       <= PPF_IND_NONE;
      ind_valid_reg <= 1'b0;
    end else begin
      tx_valid_reg  <= 1'b0;
      tx_msg_reg    <= PPF_MSG_NONE;
      tx_cause_reg  <= 4'h0;
      tx_diag_reg   <= 8'h00;
      ind_valid_reg <= 1'b0;
      ind_reg       <= PPF_IND_NONE;
      if (prot_err) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_PROT_ERR;
        if (send_err) begin
          tx_valid_reg <= 1'b1;
          tx_msg_reg   <= PPF_MSG_PROT_ERR;
          tx_cause_reg <= rx_bad ? CAUSE_CONTENT : CAUSE_STATE;
          tx_diag_reg  <= rx_bad ? link.le_ie_id : {4'h0, link.le_msg};
        end
      end else if (ev_misal || (rst_exp && !rst_second_reg)) begin
        tx_valid_reg  <= 1'b1;
        tx_msg_reg    <= PPF_MSG_RST_COM;
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_RST_COM;
      end else if (rst_exp) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_RST_ERR;
      end else if (rx_rstc) begin
        tx_valid_reg  <= 1'b1;
        tx_msg_reg    <= PPF_MSG_RST_ACK;
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_RST_IND;
      end else if (rx_rsta) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_RST_ACK;
      end else if (take_com) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= rx_os ? PPF_IND_OS_COM : PPF_IND_SO_COM;
      end else if (rx_rej) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_SO_REJ;
      end else if ((mg_ack || mg_rej) && in_lereq) begin
        tx_valid_reg  <= 1'b1;
        tx_msg_reg    <= mg_ack ? PPF_MSG_SO_ACK : PPF_MSG_SO_REJ;
      end else if (req_start) begin
        tx_valid_reg  <= 1'b1;
        tx_msg_reg    <= PPF_MSG_SO_REQ;
      end else if (req_exp && in_anreq) begin
        ind_valid_reg <= 1'b1;
        ind_reg       <= PPF_IND_SO_ERR;
      end
    end
  end

  assign link.an_valid               = tx_valid_reg;
  assign link.an_msg                 = tx_msg_reg;
  assign link.an_cause               = tx_cause_reg;
  assign link.an_diag                = tx_diag_reg;
  assign state_o                     = state_reg;
  assign ind_o                       = ind_reg;
  assign ind_valid_o                 = ind_valid_reg;
  assign send_sequence_variable_o    = vs_reg;
  assign receive_sequence_variable_o = vr_reg;
endmodule : ppf_an_end

// ### inc/ppf_pkg.sv
// Purpose: shared constants and types for the protection protocol ends
// Assumes: 125 MHz system clock; messages arrive pre-parsed as codes
// Notes:   timer counts derive from nominal times and clock period
package ppf_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned REQ_TIMEOUT_MS  = 1500;
  localparam int unsigned RST_TIMEOUT_MS  = 20000;
  localparam int unsigned GRD_TIMEOUT_MS  = 10000;
  localparam int unsigned REQ_CYCLES      = (REQ_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RST_CYCLES      = (RST_TIMEOUT_MS / CLK_PERIOD_NS) * 1000000;
  localparam int unsigned GRD_CYCLES      = (GRD_TIMEOUT_MS / CLK_PERIOD_NS) * 1000000;
  localparam int          TMR_W           = 32;
  localparam int          SEQ_W           = 7;
  localparam logic [SEQ_W-1:0] SEQ_RESET  = 7'h00;

  // message codes on the link
  typedef enum logic [3:0] {
    PPF_MSG_NONE     = 4'h0,
    PPF_MSG_SO_REQ   = 4'h1,
    PPF_MSG_SO_COM   = 4'h2,
    PPF_MSG_OS_COM   = 4'h3,
    PPF_MSG_SO_ACK   = 4'h4,
    PPF_MSG_SO_REJ   = 4'h5,
    PPF_MSG_RST_COM  = 4'h6,
    PPF_MSG_RST_ACK  = 4'h7,
    PPF_MSG_PROT_ERR = 4'h8
  } ppf_msg_type;

  // protocol error causes
  localparam logic [3:0] CAUSE_CONTENT   = 4'h6;
  localparam logic [3:0] CAUSE_STATE     = 4'h8;

  // management indications from the access side
  typedef enum logic [3:0] {
    PPF_IND_NONE      = 4'h0,
    PPF_IND_SO_COM    = 4'h1,
    PPF_IND_OS_COM    = 4'h2,
    PPF_IND_SO_REJ    = 4'h3,
    PPF_IND_SO_ERR    = 4'h4,
    PPF_IND_RST_COM   = 4'h5,
    PPF_IND_RST_ERR   = 4'h6,
    PPF_IND_RST_IND   = 4'h7,
    PPF_IND_RST_ACK   = 4'h8,
    PPF_IND_PROT_ERR  = 4'h9
  } ppf_ind_type;

  typedef enum logic [2:0] {
    null_state                        = 3'b001,
    requested_by_access_network_state = 3'b010,
    requested_by_exchange_state       = 3'b100
  } ppf_state_type;
endpackage : ppf_pkg

// ### inc/ppf_link_if.sv
// Purpose: message link between access-side and exchange-side entities
// Assumes: one message per valid cycle, same clock on both ends
// Notes:   ie_ok flags: length and codepoint checks of mandatory elements
`timescale 1ns/10ps
interface ppf_link_if;
  import ppf_pkg::*;
  logic        an_valid;
  ppf_msg_type an_msg;
  logic [3:0]  an_cause;
  logic [7:0]  an_diag;
  logic        le_valid;
  ppf_msg_type le_msg;
  logic        le_len_ok;
  logic        le_code_ok;
  logic [7:0]  le_ie_id;

  modport an_end (output an_valid, output an_msg, output an_cause, output an_diag,
                  input le_valid, input le_msg, input le_len_ok, input le_code_ok,
                  input le_ie_id);
  modport le_end (input an_valid, input an_msg, input an_cause, input an_diag,
                  output le_valid, output le_msg, output le_len_ok, output le_code_ok,
                  output le_ie_id);
endinterface : ppf_link_if

// ### rtl/ppf_le_end.sv
// Purpose: exchange-side message source and error reaction
// Assumes: user supplies message and element check results per cycle
// Notes:   never answers an error with a message
`timescale 1ns/10ps
module ppf_le_end
  import ppf_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  ppf_link_if.le_end       link,
  input  wire logic        send_i,
  input  ppf_msg_type      msg_i,
  input  wire logic        len_ok_i,
  input  wire logic        code_ok_i,
  input  wire logic [7:0]  ie_id_i,
  input  wire logic        rx_bad_i,
  input  wire logic        rx_unexp_i,
  output logic             rx_valid_o,
  output ppf_msg_type      rx_msg_o,
  output logic [3:0]       rx_cause_o,
  output logic             prot_err_ind_o
);
  logic        tx_valid_reg;
  ppf_msg_type tx_msg_reg;
  logic        tx_len_reg, tx_code_reg;
  logic [7:0]  tx_ie_reg;
  logic        rx_valid_reg;
  ppf_msg_type rx_msg_reg;
  logic [3:0]  rx_cause_reg;
  logic        err_reg;

  wire logic rx_err = link.an_valid && (rx_bad_i || rx_unexp_i);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_reg <= 1'b0;
      tx_msg_reg   <= PPF_MSG_NONE;
      tx_len_reg   <= 1'b1;
      tx_code_reg  <= 1'b1;
      tx_ie_reg    <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_msg_reg   <= PPF_MSG_NONE;
      rx_cause_reg <= 4'h0;
      err_reg      <= 1'b0;
    end else begin
      tx_valid_reg <= send_i;
      tx_msg_reg   <= msg_i;
      tx_len_reg   <= len_ok_i;
      tx_code_reg  <= code_ok_i;
      tx_ie_reg    <= ie_id_i;
      // errored messages are dropped and only reported
      rx_valid_reg <= link.an_valid && !rx_err;
      rx_msg_reg   <= link.an_msg;
      rx_cause_reg <= link.an_cause;
      err_reg      <= rx_err;
    end
  end

  assign link.le_valid   = tx_valid_reg;
  assign link.le_msg     = tx_msg_reg;
  assign link.le_len_ok  = tx_len_reg;
  assign link.le_code_ok = tx_code_reg;
  assign link.le_ie_id   = tx_ie_reg;
  assign rx_valid_o      = rx_valid_reg;
  assign rx_msg_o        = rx_msg_reg;
  assign rx_cause_o      = rx_cause_reg;
  assign prot_err_ind_o  = err_reg;
endmodule : ppf_le_end

// ### verif/ppf_link_assertions.sv
// Purpose: link checks between access and exchange protection ends
// Assumes: one clock; rst_i asynchronous, active high
// Notes:   switch-over state is inferred from link traffic alone
`timescale 1ns/10ps
module ppf_link_assertions
  import ppf_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       an_valid,
  input  ppf_msg_type     an_msg,
  input  wire logic [3:0] an_cause,
  input  wire logic [7:0] an_diag,
  input  wire logic       le_valid,
  input  ppf_msg_type     le_msg,
  input  wire logic       le_len_ok,
  input  wire logic       le_code_ok,
  input  wire logic [7:0] le_ie_id
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic quiet_reg;
  logic pend_reg;
  logic exch_reg;
  wire  rx_ok   = le_valid && le_len_ok && le_code_ok;
  wire  rx_bad  = le_valid && !(le_len_ok && le_code_ok);
  wire  rx_com  = rx_ok && (le_msg == PPF_MSG_SO_COM || le_msg == PPF_MSG_OS_COM);
  wire  rx_rej  = rx_ok && le_msg == PPF_MSG_SO_REJ;
  wire  an_rst  = an_valid && (an_msg == PPF_MSG_RST_COM || an_msg == PPF_MSG_RST_ACK);
  wire  an_done = an_valid && (an_msg == PPF_MSG_SO_ACK || an_msg == PPF_MSG_SO_REJ);
  wire  st_err  = an_valid && an_msg == PPF_MSG_PROT_ERR && an_cause == CAUSE_STATE;
  // reset timer already runs in the cycle its command leaves
  wire  quiet   = quiet_reg || (an_valid && an_msg == PPF_MSG_RST_COM);
  // quiet: sequence reset timer running, error messages withheld
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_reg <= 1'b0;
      pend_reg  <= 1'b0;
      exch_reg  <= 1'b0;
    end else begin
      quiet_reg <= (an_valid && an_msg == PPF_MSG_RST_COM)
                   || (quiet_reg && !(le_valid && le_msg == PPF_MSG_RST_ACK));
      pend_reg  <= (an_valid && an_msg == PPF_MSG_SO_REQ)
                   || (pend_reg && !an_rst && !rx_com && !rx_rej);
      exch_reg  <= rx_com || (exch_reg && !an_rst && !an_done);
    end
  end

  content_err_reply_a: assert property (
    rx_bad && !quiet && le_msg != PPF_MSG_RST_COM && le_msg != PPF_MSG_RST_ACK
    |=> an_valid && an_msg == PPF_MSG_PROT_ERR && an_cause == CAUSE_CONTENT
        && an_diag == $past(le_ie_id))
    else $error("content error not answered");
  quiet_no_err_a: assert property (
    quiet |-> !(an_valid && an_msg == PPF_MSG_PROT_ERR))
    else $error("error message sent while reset timer runs");
  ack_msg_unexp_a: assert property (
    rx_ok && le_msg == PPF_MSG_SO_ACK && !quiet
    |=> st_err && an_diag == {4'h0, $past(le_msg)})
    else $error("unexpected message not answered");
  rej_unexp_a: assert property (
    rx_rej && !pend_reg && !quiet |=> st_err)
    else $error("stray reject not answered");
  rej_accept_a: assert property (
    rx_rej && pend_reg |=> !an_valid)
    else $error("accepted reject produced a message");
  com_unexp_a: assert property (
    rx_com && exch_reg && !quiet |=> st_err)
    else $error("repeated command not answered");
  com_accept_a: assert property (
    rx_com && !exch_reg |=> !an_valid)
    else $error("accepted command produced a message");
  rst_ack_reply_a: assert property (
    rx_ok && le_msg == PPF_MSG_RST_COM |=> an_valid && an_msg == PPF_MSG_RST_ACK)
    else $error("sequence reset not acknowledged");
  le_no_err_a: assert property (
    !(le_valid && le_msg == PPF_MSG_PROT_ERR))
    else $error("exchange end sent an error message");
  ack_needs_exch_a: assert property (
    an_done |-> exch_reg)
    else $error("ack or reject sent outside exchange request");
endmodule : ppf_link_assertions

// ### verif/tb.sv
// Purpose: self-checking bench joining both protection ends
// Assumes: protocol timers too long to expire here; event paths only
// Notes:   table rows first, then sequence, exchange and reset cases
`timescale 1ns/10ps
module tb;
  import ppf_pkg::*;
  typedef struct packed {
    logic [2:0]    act;  // 0 ack 1 req 2 rej 3 link 4 misalign
    ppf_msg_type   msg;
    logic [1:0]    ok;   // length ok, codepoint ok
    logic [1:0]    an;   // 0 none 1 expected 2 unchecked
    ppf_msg_type   amsg;
    ppf_ind_type   ind;
    ppf_state_type st;
  } ppf_row_type;
  localparam ppf_state_type S0 = null_state;
  localparam ppf_state_type S1 = requested_by_access_network_state;
  localparam ppf_state_type S2 = requested_by_exchange_state;
  logic             clock_i, rst_i, mgmt_ack, mgmt_req, mgmt_rej, misalign, inc_s, inc_r;
  logic             le_send, le_len, le_code, bad_en, unexp_en, ind_valid, rx_valid, prot_err;
  logic             got_an, got_ind, got_rx, got_pe;
  ppf_msg_type      le_msg, g_msg, r_msg, g_rx;
  ppf_ind_type      ind, g_ind;
  ppf_state_type    state;
  logic [3:0]       g_cause, g_rcause, r_cause;
  logic [7:0]       g_diag, ie_id;
  logic [SEQ_W-1:0] s_seq, r_seq;
  int               n_mismatch, checks_done;
  ppf_row_type      rows [17];

  ppf_link_if lnk ();
  ppf_an_end ppf_an_end_inst (.clock_i(clock_i), .rst_i(rst_i), .link(lnk),
    .mgmt_ack_i(mgmt_ack), .mgmt_req_i(mgmt_req), .mgmt_rej_i(mgmt_rej),
    .misalign_i(misalign), .seq_inc_s_i(inc_s), .seq_inc_r_i(inc_r), .state_o(state),
    .ind_o(ind), .ind_valid_o(ind_valid), .send_sequence_variable_o(s_seq),
    .receive_sequence_variable_o(r_seq));
  ppf_le_end ppf_le_end_inst (.clock_i(clock_i), .rst_i(rst_i), .link(lnk),
    .send_i(le_send), .msg_i(le_msg), .len_ok_i(le_len), .code_ok_i(le_code),
    .ie_id_i(ie_id), .rx_bad_i(bad_en && lnk.an_valid), .rx_unexp_i(unexp_en && lnk.an_valid),
    .rx_valid_o(rx_valid), .rx_msg_o(r_msg), .rx_cause_o(r_cause), .prot_err_ind_o(prot_err));
  ppf_link_assertions ppf_link_assertions_inst (.clock_i(clock_i), .rst_i(rst_i),
    .an_valid(lnk.an_valid), .an_msg(lnk.an_msg), .an_cause(lnk.an_cause),
    .an_diag(lnk.an_diag), .le_valid(lnk.le_valid), .le_msg(lnk.le_msg),
    .le_len_ok(lnk.le_len_ok), .le_code_ok(lnk.le_code_ok), .le_ie_id(lnk.le_ie_id));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask : tick

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check

  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // one request, then four cycles of watching both ends
  task automatic do_op(input logic [2:0] act, input ppf_msg_type m, input logic [1:0] ok);
    mgmt_ack = (act == 3'd0);
    mgmt_req = (act == 3'd1);
    mgmt_rej = (act == 3'd2);
    le_send  = (act == 3'd3);
    misalign = (act == 3'd4);
    le_msg   = m;
    {le_len, le_code} = ok;
    tick();
    {mgmt_ack, mgmt_req, mgmt_rej, le_send, misalign} = 5'h00;
    {got_an, got_ind, got_rx, got_pe} = 4'h0;
    g_msg = PPF_MSG_NONE;
    g_rx = PPF_MSG_NONE;
    g_ind = PPF_IND_NONE;
    g_cause = 4'h0;
    g_rcause = 4'h0;
    g_diag = 8'h00;
    repeat (4) begin
      if (lnk.an_valid === 1'b1) begin
        got_an = 1'b1;
        g_msg = lnk.an_msg;
        g_cause = lnk.an_cause;
        g_diag = lnk.an_diag;
      end
      if (ind_valid === 1'b1) begin
        got_ind = 1'b1;
        g_ind = ind;
      end
      if (rx_valid === 1'b1) begin
        got_rx = 1'b1;
        g_rx = r_msg;
        g_rcause = r_cause;
      end
      if (prot_err === 1'b1) got_pe = 1'b1;
      tick();
    end
  endtask : do_op

  initial begin
    {mgmt_ack, mgmt_req, mgmt_rej, misalign, inc_s, inc_r, le_send, bad_en, unexp_en} = '0;
    {le_len, le_code} = 2'b11;
    le_msg = PPF_MSG_NONE;
    ie_id = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    rows = '{
      '{3'd1, PPF_MSG_NONE, 2'b11, 2'd1, PPF_MSG_SO_REQ, PPF_IND_NONE, S1},
      '{3'd3, PPF_MSG_SO_REJ, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_SO_REJ, S0},
      '{3'd3, PPF_MSG_SO_REJ, 2'b11, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S0},
      '{3'd3, PPF_MSG_SO_COM, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_SO_COM, S2},
      '{3'd3, PPF_MSG_SO_COM, 2'b11, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S2},
      '{3'd1, PPF_MSG_NONE, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_NONE, S2},
      '{3'd3, PPF_MSG_SO_COM, 2'b01, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S2},
      '{3'd3, PPF_MSG_SO_COM, 2'b10, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S2},
      '{3'd0, PPF_MSG_NONE, 2'b11, 2'd1, PPF_MSG_SO_ACK, PPF_IND_NONE, S0},
      '{3'd0, PPF_MSG_NONE, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_NONE, S0},
      '{3'd1, PPF_MSG_NONE, 2'b11, 2'd1, PPF_MSG_SO_REQ, PPF_IND_NONE, S1},
      '{3'd2, PPF_MSG_NONE, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_NONE, S1},
      '{3'd3, PPF_MSG_OS_COM, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_OS_COM, S2},
      '{3'd3, PPF_MSG_OS_COM, 2'b11, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S2},
      '{3'd2, PPF_MSG_NONE, 2'b11, 2'd1, PPF_MSG_SO_REJ, PPF_IND_NONE, S0},
      '{3'd3, PPF_MSG_OS_COM, 2'b11, 2'd0, PPF_MSG_NONE, PPF_IND_OS_COM, S2},
      '{3'd3, PPF_MSG_SO_ACK, 2'b11, 2'd1, PPF_MSG_PROT_ERR, PPF_IND_PROT_ERR, S2}
    };
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    check(state === S0 && s_seq === SEQ_RESET && r_seq === SEQ_RESET, "reset values");
    foreach (rows[i]) begin
      ie_id = 8'h40 + 8'(i);
      do_op(rows[i].act, rows[i].msg, rows[i].ok);
      if (rows[i].an != 2'd2) begin
        check(got_an === rows[i].an[0], "answer presence");
        check(got_ind === (rows[i].ind != PPF_IND_NONE), "indication presence");
      end
      if (rows[i].an == 2'd1)
        check(g_msg === rows[i].amsg && got_rx && g_rx === rows[i].amsg, "answer");
      if (got_an && g_msg === PPF_MSG_PROT_ERR)
        check(rows[i].ok == 2'b11 ? (g_cause === CAUSE_STATE && g_diag === {4'h0, rows[i].msg})
              : (g_cause === CAUSE_CONTENT && g_diag === ie_id), "error cause");
      if (got_rx && g_rx === PPF_MSG_PROT_ERR)
        check(g_rcause === (rows[i].ok == 2'b11 ? CAUSE_STATE : CAUSE_CONTENT),
              "relayed cause");
      if (rows[i].ind != PPF_IND_NONE)
        check(g_ind === rows[i].ind, "indication code");
      check(state === rows[i].st, "state");
    end
    do_op(3'd0, PPF_MSG_NONE, 2'b11);
    do_op(3'd1, PPF_MSG_NONE, 2'b11);
    do_op(3'd3, PPF_MSG_SO_COM, 2'b11);
    check(g_ind === PPF_IND_SO_COM && state === S2, "command from request");
    inc_s = 1'b1;
    inc_r = 1'b1;
    tick();
    inc_r = 1'b0;
    tick();
    inc_s = 1'b0;
    tick();
    check(s_seq === 7'h02 && r_seq === 7'h01, "sequence count");
    do_op(3'd3, PPF_MSG_RST_COM, 2'b11);
    check(g_msg === PPF_MSG_RST_ACK && g_ind === PPF_IND_RST_IND && state === S0
          && s_seq === SEQ_RESET && r_seq === SEQ_RESET, "sequence reset reply");
    bad_en = 1'b1;
    do_op(3'd1, PPF_MSG_NONE, 2'b11);
    check(got_an && got_pe && !got_rx, "exchange content error");
    bad_en = 1'b0;
    unexp_en = 1'b1;
    do_op(3'd3, PPF_MSG_SO_REJ, 2'b11);
    do_op(3'd1, PPF_MSG_NONE, 2'b11);
    check(got_an && got_pe && !got_rx, "exchange unexpected");
    unexp_en = 1'b0;
    inc_s = 1'b1;
    tick();
    inc_s = 1'b0;
    do_op(3'd4, PPF_MSG_NONE, 2'b11);
    check(g_msg === PPF_MSG_RST_COM && g_ind === PPF_IND_RST_COM && state === S0
          && s_seq === SEQ_RESET && r_seq === SEQ_RESET, "misalignment");
    do_op(3'd3, PPF_MSG_SO_REJ, 2'b11);
    check(!got_an && g_ind === PPF_IND_PROT_ERR && state === S0, "quiet unexpected");
    do_op(3'd3, PPF_MSG_SO_COM, 2'b01);
    check(!got_an && g_ind === PPF_IND_PROT_ERR, "quiet content error");
    inc_s = 1'b1;
    do_op(3'd1, PPF_MSG_NONE, 2'b11);
    inc_s = 1'b0;
    rst_i = 1'b1;
    tick();
    rst_i = 1'b0;
    check(state === S0 && ind_valid === 1'b0 && lnk.an_valid === 1'b0
          && s_seq === SEQ_RESET, "mid-run reset");
    do_op(3'd3, PPF_MSG_SO_REJ, 2'b11);
    check(got_an && g_msg === PPF_MSG_PROT_ERR && g_cause === CAUSE_STATE,
          "error message after reset");
    stop_test();
  end
endmodule : tb
